// >>> src/fpe_defines.vh
`ifndef FPE_DEFINES_VH
`define FPE_DEFINES_VH

// Register byte offsets
`define FPE_OFS_CONTROL     4'h0
`define FPE_OFS_KEY         4'h4
`define FPE_OFS_IRQ_STATUS  4'h8
`define FPE_OFS_IRQ_MASK    4'hc

// Control register field positions
`define FPE_BIT_START       15
`define FPE_BIT_ENABLE      14
`define FPE_BIT_ERROR       13
`define FPE_BIT_ERASE       6

// Unlock key values
`define FPE_KEY_FIRST       8'h55
`define FPE_KEY_SECOND      8'haa

// Operation select encodings
`define FPE_OP_SEGMENT      4'hd
`define FPE_OP_PAGE         4'h2
`define FPE_OP_WORD         4'h3

// Operation duration in fast RC oscillator cycles
`define FPE_OP_CYCLES       168517

// Interrupt status bit positions
`define FPE_IRQ_DONE        0
`define FPE_IRQ_ERROR       1

`endif

// >>> src/fpe_duration_timer.v
`default_nettype none

// ****************************************************************
// Duration counter ticking on oscillator enable pulses
// ****************************************************************
module fpe_duration_timer
#(
    parameter WIDTH = 18
)
(
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] count_in,
    input  wire             tick_in,
    output wire             busy_out,
    output reg              done_out
);

    reg [WIDTH-1:0] remain_reg;   // Ticks left

    assign busy_out = (remain_reg != {WIDTH{1'b0}});

    // Count down one per oscillator tick
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            remain_reg <= {WIDTH{1'b0}};
            done_out   <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (load_in)
                remain_reg <= count_in;
            else if (busy_out && tick_in)
            begin
                remain_reg <= remain_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                // Final tick ends the operation
                if (remain_reg == {{(WIDTH-1){1'b0}}, 1'b1})
                    done_out <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/fpe_flash_control.v
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`default_nettype none
`include "fpe_defines.vh"

module fpe_flash_control
#(
    parameter OP_CYCLES = `FPE_OP_CYCLES,   // Oscillator ticks per operation
    parameter CNT_WIDTH = 18
)
(
    input  wire        clk_in,
    input  wire        rst_in,          // Warm reset: leaves control bits
    input  wire        por_in,          // Power-on reset: clears all
    input  wire        osc_tick_in,     // One pulse per fast RC cycle
    // AXI4-Lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Flash array side
    output reg         segment_erase_out,   // One-cycle start pulses
    output reg         page_erase_out,
    output reg         word_program_out,
    output wire        cpu_stall_out,       // Hold processor while busy
    output wire        irq_out
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg       start_reg;        // Operation in progress
    reg       enable_reg;       // Program/erase allowed
    reg       error_reg;        // Sequence error flag
    reg       erase_reg;        // Erase versus program
    reg [3:0] opsel_reg;        // Operation select
    reg [1:0] key_state_reg;    // 0 none, 1 first seen, 2 unlocked
    reg [1:0] irq_status_reg;   // Sticky events
    reg [1:0] irq_mask_reg;     // Event enables
    reg       aw_hold_reg;      // Captured write address valid
    reg [3:0] aw_addr_reg;
    reg       w_hold_reg;       // Captured write data valid
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire       timer_busy;
    wire       timer_done;
    reg        load_pulse;      // Starts the duration timer
    reg        done_event;
    reg        err_event;

    localparam [1:0] KEY_NONE  = 2'h0;
    localparam [1:0] KEY_FIRST = 2'h1;
    localparam [1:0] KEY_OPEN  = 2'h2;

    // ****************************************************************
    // Write channel capture
    // ****************************************************************
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;

    wire wr_fire = aw_hold_reg && w_hold_reg;   // Both halves present
    wire lo_en   = w_strb_reg[0];
    wire hi_en   = w_strb_reg[1];
    wire wr_ctl  = wr_fire && (aw_addr_reg == `FPE_OFS_CONTROL);
    wire wr_key  = wr_fire && (aw_addr_reg == `FPE_OFS_KEY) && lo_en;
    wire wr_ist  = wr_fire && (aw_addr_reg == `FPE_OFS_IRQ_STATUS) && lo_en;
    wire wr_imk  = wr_fire && (aw_addr_reg == `FPE_OFS_IRQ_MASK) && lo_en;
    wire mapped  = (aw_addr_reg == `FPE_OFS_CONTROL) || (aw_addr_reg == `FPE_OFS_KEY) ||
                   (aw_addr_reg == `FPE_OFS_IRQ_STATUS) || (aw_addr_reg == `FPE_OFS_IRQ_MASK);

    // Address and data taken in either order
    always @(posedge clk_in)
    begin
        if (rst_in || por_in)
        begin
            aw_hold_reg  <= 1'b0;
            aw_addr_reg  <= 4'h0;
            w_hold_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                // Unmapped offsets answer SLVERR
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Start decode
    // ****************************************************************
    wire start_try = wr_ctl && hi_en && w_data_reg[`FPE_BIT_START] && !start_reg && !timer_busy;
    wire op_erase  = hi_en ? w_data_reg[`FPE_BIT_ERASE] : erase_reg;
    wire [3:0] op_code = lo_en ? w_data_reg[3:0] : opsel_reg;
    wire op_enable = w_data_reg[`FPE_BIT_ENABLE];

    // Check sequence and decode the operation
    always @*
    begin
        load_pulse        = 1'b0;
        err_event         = 1'b0;
        segment_erase_out = 1'b0;
        page_erase_out    = 1'b0;
        word_program_out  = 1'b0;
        if (start_try)
        begin
            if (!op_enable || key_state_reg != KEY_OPEN)
                err_event = 1'b1;
            else if (op_erase)
            begin
                if (op_code == `FPE_OP_SEGMENT)
                    segment_erase_out = 1'b1;
                else if (op_code == `FPE_OP_PAGE)
                    page_erase_out = 1'b1;
            end
            else if (op_code == `FPE_OP_WORD)
                word_program_out = 1'b1;
            load_pulse = segment_erase_out || page_erase_out || word_program_out;
        end
    end

    // ****************************************************************
    // Control and key registers
    // ****************************************************************
    // Only power-on clears control; warm reset just drops the key
    always @(posedge clk_in)
    begin
        if (por_in)
        begin
            start_reg  <= 1'b0;
            enable_reg <= 1'b0;
            error_reg  <= 1'b0;
            erase_reg  <= 1'b0;
            opsel_reg  <= 4'h0;
        end
        else
        begin
            if (wr_ctl && hi_en)
            begin
                enable_reg <= w_data_reg[`FPE_BIT_ENABLE];
                erase_reg  <= w_data_reg[`FPE_BIT_ERASE];
            end
            if (wr_ctl && lo_en)
                opsel_reg <= w_data_reg[3:0];
            if (load_pulse)
                start_reg <= 1'b1;
            else if (timer_done)
                start_reg <= 1'b0;
            if (err_event)
                error_reg <= 1'b1;
            else if (timer_done)
                error_reg <= 1'b0;
        end
    end

    // Key unlock tracker; any other write breaks the pair
    always @(posedge clk_in)
    begin
        if (rst_in || por_in)
            key_state_reg <= KEY_NONE;
        else if (wr_key)
        begin
            if (w_data_reg[7:0] == `FPE_KEY_FIRST)
                key_state_reg <= KEY_FIRST;
            else if (key_state_reg == KEY_FIRST && w_data_reg[7:0] == `FPE_KEY_SECOND)
                key_state_reg <= KEY_OPEN;
            else
                key_state_reg <= KEY_NONE;
        end
        else if (wr_fire)
            key_state_reg <= KEY_NONE;
    end

    // ****************************************************************
    // Operation timing
    // ****************************************************************
    wire [31:0] op_cycles_full = OP_CYCLES;    // Parameter as a sized word

    fpe_duration_timer
    #(
        .WIDTH (CNT_WIDTH)
    )
    u_timer
    (
        .clk_in   (clk_in),
        .rst_in   (por_in),
        .load_in  (load_pulse),
        .count_in (op_cycles_full[CNT_WIDTH-1:0]),
        .tick_in  (osc_tick_in),
        .busy_out (timer_busy),
        .done_out (timer_done)
    );

    assign cpu_stall_out = start_reg;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always @*
        done_event = timer_done;

    // Set wins over write-one-to-clear
    always @(posedge clk_in)
    begin
        if (rst_in || por_in)
        begin
            irq_status_reg <= 2'b00;
            irq_mask_reg   <= 2'b00;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~(wr_ist ? w_data_reg[1:0] : 2'b00))
                              | {err_event, done_event};
            if (wr_imk)
                irq_mask_reg <= w_data_reg[1:0];
        end
    end

    assign irq_out = |(irq_status_reg & irq_mask_reg);

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    // One-cycle read answer
    always @(posedge clk_in)
    begin
        if (rst_in || por_in)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case ({s_axi_araddr[3:2], 2'b00})
                `FPE_OFS_CONTROL:
                    s_axi_rdata <= {16'h0000, start_reg, enable_reg, error_reg, 6'h00,
                                    erase_reg, 2'b00, opsel_reg};
                `FPE_OFS_KEY:
                    s_axi_rdata <= 32'h0000_0000;
                `FPE_OFS_IRQ_STATUS:
                    s_axi_rdata <= {30'h0000_0000, irq_status_reg};
                `FPE_OFS_IRQ_MASK:
                    s_axi_rdata <= {30'h0000_0000, irq_mask_reg};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

`default_nettype wire

// >>> test/fpe_flash_control_properties.sv
`default_nettype none
// ****************************************************************
// Checker on the control block ports
// ****************************************************************
module fpe_flash_control_properties
#(
    parameter OP_CYCLES = 5
)
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        por_in,
    input wire logic        osc_tick_in,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        segment_erase_out,
    input wire logic        page_erase_out,
    input wire logic        word_program_out,
    input wire logic        cpu_stall_out,
    input wire logic        irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] tick_cnt_reg;  // Oscillator ticks seen while busy
    wire  [2:0]  pulses = {segment_erase_out, page_erase_out, word_program_out};

    // Count ticks during an operation; slack of one tick below and two above for the load and done edges
    always @(posedge clk_in)
    begin
        if (rst_in || por_in || !cpu_stall_out)
            tick_cnt_reg <= 32'h0;
        else if (osc_tick_in)
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in || por_in);

    pulse_onehot_a: assert property ($onehot0(pulses))
        else $error("more than one start pulse");
    start_busy_a: assert property (pulses != 3'b000 |=> cpu_stall_out)
        else $error("start pulse without busy");
    busy_quiet_a: assert property (cpu_stall_out |-> pulses == 3'b000)
        else $error("start pulse while busy");
    op_length_a: assert property ($fell(cpu_stall_out) |->
        tick_cnt_reg >= OP_CYCLES - 1 && tick_cnt_reg <= OP_CYCLES + 2)
        else $error("operation length wrong");
    por_clear_a: assert property (disable iff (rst_in) por_in |=> !cpu_stall_out && !irq_out)
        else $error("power-on reset left state");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");

    cover property (segment_erase_out);
    cover property (page_erase_out);
    cover property (word_program_out);
endmodule

bind fpe_flash_control fpe_flash_control_properties #(.OP_CYCLES(OP_CYCLES))
    fpe_flash_control_properties_inst (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
    .osc_tick_in(osc_tick_in), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .segment_erase_out(segment_erase_out), .page_erase_out(page_erase_out),
    .word_program_out(word_program_out), .cpu_stall_out(cpu_stall_out), .irq_out(irq_out));
`default_nettype wire

// >>> test/fpe_flash_control_tb_top.sv
`default_nettype none
// ****************************************************************
// Bench for the flash control block
// ****************************************************************
module fpe_flash_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OPC = 20;    // Long enough to read back while busy
    // Pulse {seg,page,word}, erase bit, operation code
    localparam logic [7:0] OPS [10] = '{8'h9d, 8'h52, 8'h23, 8'h1f, 8'h13,
                                        8'h0f, 8'h0d, 8'h02, 8'h00, 8'h11};
    logic             clk_in, rst_in, por_in;
    logic             osc_tick_in = 1'b0;
    logic [3:0]       s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]      s_axi_wdata;
    logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic        segment_erase_out, page_erase_out, word_program_out;
    wire logic        cpu_stall_out, irq_out;
    logic [7:0]       rnd = 8'd71;  // Random source
    int               fails = 0, n_compared = 0, cyc = 0;
    logic [31:0]      exq[$];       // Notes of expected read data
    logic [2:0]       pq[$];        // Notes of expected start pulses

    fpe_flash_control #(.OP_CYCLES(OPC)) fpe_flash_control_inst (
        .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .osc_tick_in(osc_tick_in),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .segment_erase_out(segment_erase_out),
        .page_erase_out(page_erase_out), .word_program_out(word_program_out),
        .cpu_stall_out(cpu_stall_out), .irq_out(irq_out));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bus write: both halves offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic da, dw;
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= {rnd, rnd, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        da = 1'b0;
        dw = 1'b0;
        while (!(da && dw))
        begin
            @(posedge clk_in);
            da = da || (s_axi_awready === 1'b1);
            dw = dw || (s_axi_wready === 1'b1);
            if (da)
                s_axi_awvalid <= 1'b0;
            if (dw)
                s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk_in); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    // Bus read: note the expectation, the watcher compares
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        exq.push_back({16'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_in); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic key;
        wr(4'h4, 16'h0055);
        wr(4'h4, 16'h00aa);
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Watcher: oldest note against each result, plus ticks and timeout
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        rnd <= lfsr(rnd);
        osc_tick_in <= rnd[0];
        if ((s_axi_rvalid & s_axi_rready) === 1'b1)
        begin
            chk("rdata", exq.pop_front(), s_axi_rdata);
            chk("rresp", 32'h0, {30'h0, s_axi_rresp});
        end
        if ((s_axi_bvalid & s_axi_bready) === 1'b1)
            chk("bresp", 32'h0, {30'h0, s_axi_bresp});
        if ({segment_erase_out, page_erase_out, word_program_out} !== 3'b000)
            chk("pulse", {29'h0, (pq.size() > 0) ? pq.pop_front() : 3'b000},
                {29'h0, segment_erase_out, page_erase_out, word_program_out});
        if (cyc == 20000)
        begin
            fails++;
            give_verdict();
        end
    end

    initial
    begin
        logic [15:0] w;
        logic [15:0] ef;    // Error bit still expected in control
        logic [7:0]  o;
        {rst_in, por_in} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h0, 4'hf, 32'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'h0000);
        wr(4'hc, 16'h0003);
        // Start with no key, then with key but not enabled
        wr(4'h0, 16'hc003);
        rd(4'h0, 16'h6003);
        rd(4'h8, 16'h0002);
        chk("irq", 32'h1, {31'h0, irq_out});
        wr(4'h8, 16'h0003);
        rd(4'h8, 16'h0000);
        chk("irq", 32'h0, {31'h0, irq_out});
        key();
        rd(4'h4, 16'h0000);
        wr(4'h0, 16'h8003);
        rd(4'h0, 16'h2003);
        wr(4'h8, 16'h0003);
        // Error flag stays until the first normal completion
        ef = 16'h2000;
        // Segment, page and word encodings under both erase settings, plus unused codes f, 0 and 1
        foreach (OPS[i])
        begin
            o = OPS[i];
            w = {9'h080, o[4], 2'b00, o[3:0]};
            key();
            if (o[7:5] != 3'b000)
                pq.push_back(o[7:5]);
            wr(4'h0, w | 16'h8000 | ({rnd, rnd} & 16'h1fb0));
            if (o[7:5] != 3'b000)
            begin
                chk("stall", 32'h1, {31'h0, cpu_stall_out});
                rd(4'h0, w | 16'h8000 | ef);
                wr(4'h0, w);
                rd(4'h0, w | 16'h8000 | ef);
                while (cpu_stall_out !== 1'b0)
                    @(posedge clk_in);
                ef = 16'h0000;
                rd(4'h0, w);
                rd(4'h8, 16'h0001);
                wr(4'h8, 16'h0001);
            end
            else
                rd(4'h0, w | ef);
        end
        // Warm reset keeps control, power-on clears it
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        rd(4'h0, 16'h4041);
        por_in <= 1'b1;
        @(posedge clk_in);
        por_in <= 1'b0;
        rd(4'h0, 16'h0000);
        repeat (2) @(posedge clk_in);
        chk("pending", 32'h0, exq.size() + pq.size());
        give_verdict();
    end
endmodule
`default_nettype wire
